// ### sar_ctrl_pkg.sv
package sar_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Result format, fixed words and queue depth
  // ----------------------------------------------------------------------
  localparam int ResultWidth = 16;
  localparam logic [15:0] AbortWord = 16'hFF00;
  localparam logic [15:0] ResultReset = 16'h0000;
  localparam int FifoDepth = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CoreClkMhz = 100;
  localparam int ConvTimeNs = 1100;
  localparam int ConvCycles = (ConvTimeNs * CoreClkMhz) / 1000;
  localparam int ConvCntWidth = 8;
  localparam logic [ConvCntWidth-1:0] ConvLast = ConvCntWidth'(ConvCycles - 1);
  localparam logic [4:0] BitCountFull = 5'h10;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    StWait = 3'b000,
    StNap = 3'b001,
    StSample = 3'b010,
    StConvert = 3'b011
  } convState_t;

  typedef struct packed {
    logic chipSelectN;
    logic conversionStartN;
    logic frameSyncIn;
    logic serialClk;
    logic powerDownIn;
  } hostPins_t;

  typedef struct packed {
    logic busy;
    logic napActive;
    logic serialDataOut;
    logic serialDataOe_n;
  } devicePins_t;

endpackage : sar_ctrl_pkg

// ### result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int Width = 16,
  parameter int Depth = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);

  localparam int Aw = $clog2(Depth);

  logic [Width-1:0] mem [Depth];
  logic [Aw:0] wrPtr_q;
  logic [Aw:0] rdPtr_q;
  logic full;
  logic empty;

  // ----------------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------------
  assign empty = (wrPtr_q == rdPtr_q);
  assign full = (wrPtr_q[Aw-1:0] == rdPtr_q[Aw-1:0]) && (wrPtr_q[Aw] != rdPtr_q[Aw]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[Aw-1:0]];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (clear) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[Aw-1:0]] <= inData;
    end
  end

endmodule : result_fifo

// ### sar_conv_readout.sv
// Operation
// - Conversion start is latched only while chip select is low.
// - Qualified start falling edge during sampling starts a conversion.
// - Start high with chip select low begins sampling from wait, nap or end.
// - Start condition present at conversion end goes straight to sampling.
// - Conversion end without start condition enters wait or nap.
// - Nap chosen when qualified start is low at conversion end.
// - Qualified start falling edge during conversion aborts it, then wait.
// - Aborted conversion reads out the fixed word FF00.
// - Reads are independent of conversion; mid-conversion reads give previous result.
// - SPI mode: MSB at chip select fall, next bits on later SCLK rises.
// - SPI mode: chip select high then low restarts the frame from MSB.
// - Frame-sync mode: MSB driven at frame sync rising edge.
// - Frame-sync mode: bits shift on SCLK rises after a fall past frame sync fall.
// - Frame-sync mode: frame sync high at busy fall reloads output with new MSB.
// - Frame-sync mode: raising frame sync again restarts the frame.
// - Conversion timed internally, finishing within 1.1 us.
// - Serial clock runs up to 40 MHz from the host; the code oversamples it at 100 MHz, needing several core cycles per phase.
// - Busy is high exactly while converting.
// - Power down high resets and powers down; low resumes.
// - Results are two's complement, 7FFF down to 8000.
`timescale 1ns/1ps
module sar_conv_readout
  import sar_ctrl_pkg::*;
#(
  parameter int FifoWidth = ResultWidth,
  parameter int FifoEntries = FifoDepth
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host pins
  input wire hostPins_t hostPins,
  // Device pins
  output devicePins_t devicePins,
  // Converter core result stream
  input wire logic [ResultWidth-1:0] sampleCode,
  output logic sampleTake,
  // Result stream towards the readout
  output logic resultValid,
  output logic [ResultWidth-1:0] resultWord
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    hostPins_t sync1;
    hostPins_t sync2;
    logic csPrev;
    logic fsPrev;
    logic sclkPrev;
    logic convQual;
    logic convQualPrev;
    convState_t state;
    logic [ConvCntWidth-1:0] convCnt;
    logic [ResultWidth-1:0] shiftReg;
    logic [4:0] bitCnt;
    logic armed;
    logic frameActive;
    logic fsMode;
    logic sdo;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [FifoWidth-1:0] fifoOut;
  logic convDone;
  logic [ResultWidth-1:0] convWord;
  logic convPush;
  logic pdLevel;

  // ----------------------------------------------------------------------
  // Pin edges, taken from the second synchroniser stage only
  // ----------------------------------------------------------------------
  logic csN;
  logic csFall;
  logic csRise;
  logic fsRise;
  logic fsFall;
  logic sclkRise;
  logic sclkFall;
  logic qualFall;
  logic busyFall;

  assign csN = s_q.sync2.chipSelectN;
  assign csFall = s_q.csPrev && !csN;
  assign csRise = !s_q.csPrev && csN;
  assign fsRise = !s_q.fsPrev && s_q.sync2.frameSyncIn;
  assign fsFall = s_q.fsPrev && !s_q.sync2.frameSyncIn;
  // The serial clock is oversampled, so each of its phases must span several core cycles.
  assign sclkRise = !s_q.sclkPrev && s_q.sync2.serialClk;
  assign sclkFall = s_q.sclkPrev && !s_q.sync2.serialClk;
  assign qualFall = s_q.convQualPrev && !s_q.convQual;
  assign pdLevel = s_q.sync2.powerDownIn;
  assign convDone = (s_q.state == StConvert) && (s_q.convCnt == ConvLast);
  assign busyFall = convDone || ((s_q.state == StConvert) && qualFall);

  // Aborts push the fixed word so a later read sees it in place of a result.
  assign convWord = qualFall ? AbortWord : sampleCode;
  assign convPush = busyFall;
  assign sampleTake = convPush && fifoInReady;

  // The queue decouples conversion from reading; a stalled reader backs up
  // conversions into it, and a full queue refuses the newest word.
  result_fifo #(
    .Width(FifoWidth),
    .Depth(FifoEntries)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(pdLevel),
    .inValid(convPush),
    .inReady(fifoInReady),
    .inData(convWord),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  assign resultValid = fifoOutValid;
  assign resultWord = fifoOut;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic frameStart;

  always_comb begin
    s_d = s_q;
    fifoPop = 1'b0;
    frameStart = 1'b0;
    s_d.sync1 = hostPins;
    s_d.sync2 = s_q.sync1;
    s_d.csPrev = csN;
    s_d.fsPrev = s_q.sync2.frameSyncIn;
    s_d.sclkPrev = s_q.sync2.serialClk;
    s_d.convQualPrev = s_q.convQual;
    if (!csN) begin
      s_d.convQual = s_q.sync2.conversionStartN;
    end

    unique case (s_q.state)
      StWait, StNap: begin
        if (s_q.sync2.conversionStartN && !csN) begin
          s_d.state = StSample;
        end
      end
      StSample: begin
        if (qualFall) begin
          s_d.state = StConvert;
          s_d.convCnt = '0;
        end
      end
      StConvert: begin
        s_d.convCnt = s_q.convCnt + 1'b1;
        if (qualFall) begin
          s_d.state = StWait;
        end else if (convDone) begin
          if (s_q.sync2.conversionStartN && !csN) begin
            s_d.state = StSample;
          end else if (!s_q.convQual) begin
            s_d.state = StNap;
          end else begin
            s_d.state = StWait;
          end
        end
      end
      default: s_d.state = StWait;
    endcase

    // Read port: outside a frame the queue drains into the shift register one word a cycle, else the held word stays.
    if (fifoOutValid && !s_q.frameActive) begin
      s_d.shiftReg = fifoOut;
      fifoPop = 1'b1;
    end
    if (csRise) begin
      s_d.frameActive = 1'b0;
    end
    if (!s_q.sync2.frameSyncIn || s_q.fsMode) begin
      s_d.fsMode = !s_q.sync2.frameSyncIn || (s_q.fsMode && !csFall);
    end
    if (csFall && s_q.sync2.frameSyncIn) begin
      frameStart = 1'b1;
      s_d.fsMode = 1'b0;
    end
    if (fsRise && !csN) begin
      frameStart = 1'b1;
      s_d.fsMode = 1'b1;
    end
    if (frameStart) begin
      s_d.frameActive = 1'b1;
      s_d.armed = 1'b0;
      s_d.bitCnt = 5'h1;
      s_d.sdo = s_d.shiftReg[ResultWidth-1];
    end else if (s_q.frameActive) begin
      if (sclkFall && (!s_q.fsMode || !s_q.sync2.frameSyncIn)) begin
        s_d.armed = 1'b1;
      end
      if (sclkRise && s_q.armed && (s_q.bitCnt < BitCountFull)) begin
        s_d.sdo = s_q.shiftReg[ResultWidth-1-int'(s_q.bitCnt[3:0])];
        s_d.bitCnt = s_q.bitCnt + 1'b1;
      end
    end
    // Busy falling with frame sync high in frame-sync mode shows the fresh result's MSB.
    if (busyFall && s_q.sync2.frameSyncIn && s_q.fsMode) begin
      s_d.shiftReg = convWord;
      s_d.sdo = convWord[ResultWidth-1];
      s_d.bitCnt = 5'h1;
      s_d.armed = 1'b0;
      fifoPop = 1'b0;
    end

    if (pdLevel) begin
      s_d.state = StWait;
      s_d.convCnt = '0;
      s_d.frameActive = 1'b0;
      s_d.shiftReg = ResultReset;
      s_d.bitCnt = '0;
      s_d.sdo = 1'b0;
      fifoPop = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        sync1: '{chipSelectN: 1'b1, conversionStartN: 1'b1, frameSyncIn: 1'b1,
                 serialClk: 1'b0, powerDownIn: 1'b0},
        sync2: '{chipSelectN: 1'b1, conversionStartN: 1'b1, frameSyncIn: 1'b1,
                 serialClk: 1'b0, powerDownIn: 1'b0},
        csPrev: 1'b1,
        fsPrev: 1'b1,
        sclkPrev: 1'b0,
        convQual: 1'b1,
        convQualPrev: 1'b1,
        state: StWait,
        convCnt: '0,
        shiftReg: ResultReset,
        bitCnt: '0,
        armed: 1'b0,
        frameActive: 1'b0,
        fsMode: 1'b0,
        sdo: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign devicePins.busy = (s_q.state == StConvert);
  assign devicePins.napActive = (s_q.state == StNap);
  assign devicePins.serialDataOut = s_q.sdo;
  // Power down also floats the pin, as does a high chip select.
  assign devicePins.serialDataOe_n = csN || pdLevel;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_busy_conv: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(devicePins.busy) |-> ($past(s_q.state) == StSample) && $past(qualFall))
    else $error("busy rose without a start edge");

  a_conv_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.state == StConvert && s_q.convCnt == '0) |-> ##[1:110] (s_q.state != StConvert))
    else $error("conversion overran its time");

  a_start_conv: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.state == StSample && qualFall && !pdLevel) |=> (s_q.state == StConvert))
    else $error("start edge did not begin conversion");

  a_abort_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.state == StConvert && qualFall && !pdLevel) |=> (s_q.state == StWait))
    else $error("abort did not enter wait");

  a_abort_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.state == StConvert && qualFall) |-> (convWord == AbortWord))
    else $error("abort word wrong");

  a_qual_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    csN |=> $stable(s_q.convQual))
    else $error("qualified start moved with chip select high");

  a_nap_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (convDone && !qualFall && !s_q.convQual && !pdLevel
     && !(s_q.sync2.conversionStartN && !csN)) |=> (s_q.state == StNap))
    else $error("nap not entered");

  a_sdo_float: assert property (@(posedge core_clk) disable iff (!rst_n)
    csN |-> devicePins.serialDataOe_n)
    else $error("data driven with chip select high");

  a_spi_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
    (csFall && s_q.sync2.frameSyncIn && !busyFall && !pdLevel)
    |=> (s_q.sdo == s_q.shiftReg[ResultWidth-1]))
    else $error("MSB not shown at frame start");

  a_bit_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.bitCnt <= BitCountFull)
    else $error("more than sixteen bits shifted");

  a_qual_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    !csN |=> (s_q.convQual == $past(s_q.sync2.conversionStartN)))
    else $error("qualified start did not follow the pin");

  a_nap_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((s_q.state == StWait || s_q.state == StNap) && s_q.sync2.conversionStartN
     && !csN && !pdLevel) |=> (s_q.state == StSample))
    else $error("sample start ignored");

  a_back_to_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    (convDone && !qualFall && !pdLevel && s_q.sync2.conversionStartN && !csN)
    |=> (s_q.state == StSample))
    else $error("no direct sampling after conversion");

  a_frame_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    (csFall && s_q.sync2.frameSyncIn && !pdLevel) |=> s_q.frameActive && (s_q.bitCnt == 5'h1))
    else $error("chip select frame did not restart");

  a_fs_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fsRise && !csN && !pdLevel) |=> (s_q.sdo == s_q.shiftReg[ResultWidth-1]))
    else $error("MSB not shown at frame sync rise");

  a_reload_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
    (busyFall && s_q.sync2.frameSyncIn && s_q.fsMode && !pdLevel)
    |=> (s_q.shiftReg == $past(convWord)) && (s_q.sdo == s_q.shiftReg[ResultWidth-1]))
    else $error("fresh result not reloaded");

  a_pd_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    pdLevel |=> (s_q.state == StWait) && !s_q.frameActive && !s_q.sdo)
    else $error("power down did not reset");

endmodule : sar_conv_readout

// ### host_model.sv
`timescale 1ns/1ps
module host_model
  import sar_ctrl_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Device pins seen by the host
  input wire devicePins_t devicePins,
  // Host pins driven towards the device
  output hostPins_t hostPins
);
  // ----------------------------------------------------------------------
  // Pin pacing
  // ----------------------------------------------------------------------
  // The serial clock idles low outside frames and runs at 80 ns inside them.
  localparam int HalfSclk = 4;

  initial begin
    hostPins = '{chipSelectN: 1'b1, conversionStartN: 1'b1, frameSyncIn: 1'b1,
                 serialClk: 1'b0, powerDownIn: 1'b0};
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Pins only change at the falling core edge, so they stay steady in quiet zones.
  task automatic setPins(input logic csN, input logic startN, input logic pd);
    hostPins.chipSelectN = csN;
    hostPins.conversionStartN = startN;
    hostPins.powerDownIn = pd;
  endtask : setPins

  task automatic sclkPulse();
    hostPins.serialClk = 1'b1;
    cyc(HalfSclk);
    hostPins.serialClk = 1'b0;
    cyc(HalfSclk);
  endtask : sclkPulse

  // ----------------------------------------------------------------------
  // Read frame
  // ----------------------------------------------------------------------
  // One word, MSB first; frames are never opened near a conversion end.
  task automatic readFrame(input logic fsMode, output logic [15:0] word, output logic oeN);
    // Chip select goes high first, so a frame left open always restarts.
    hostPins.chipSelectN = 1'b1;
    cyc(8);
    hostPins.frameSyncIn = !fsMode; // Held high for chip-select frames.
    hostPins.chipSelectN = 1'b0;
    cyc(8);
    if (fsMode) begin
      hostPins.frameSyncIn = 1'b1;
      cyc(8);
    end
    word[15] = devicePins.serialDataOut;
    oeN = devicePins.serialDataOe_n;
    if (fsMode) begin
      hostPins.frameSyncIn = 1'b0;
      cyc(HalfSclk);
    end
    // The first rise comes before any fall, so it must not shift.
    sclkPulse();
    for (int i = 14; i >= 0; i--) begin
      sclkPulse();
      word[i] = devicePins.serialDataOut;
    end
    hostPins.chipSelectN = 1'b1;
    hostPins.frameSyncIn = 1'b1;
    cyc(8);
  endtask : readFrame
endmodule : host_model

// ### test_sar_conv_readout.sv
`timescale 1ns/1ps
module test_sar_conv_readout;
  import sar_ctrl_pkg::*;
  logic core_clk;
  logic rst_n;
  hostPins_t hostPins;
  devicePins_t devicePins;
  logic [15:0] sampleCode;
  logic sampleTake;
  logic resultValid;
  logic [15:0] resultWord;
  logic [15:0] word;
  logic oeN;
  int nMismatch;
  int nChecks;
  int nTake;

  sar_conv_readout sar_conv_readout_i (.core_clk(core_clk), .rst_n(rst_n),
    .hostPins(hostPins), .devicePins(devicePins), .sampleCode(sampleCode),
    .sampleTake(sampleTake), .resultValid(resultValid), .resultWord(resultWord));
  host_model host_model_i (.core_clk(core_clk), .devicePins(devicePins), .hostPins(hostPins));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Queue takes stand for one cycle, so they are counted away from the launching edge.
  always @(negedge core_clk) begin
    if (sampleTake === 1'b1) begin
      nTake++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endOfTest

  // Waits out a running conversion and returns how many cycles busy stayed high after the call.
  task automatic waitConv(input logic raiseStart, output int n);
    n = 0;
    while (devicePins.busy === 1'b1 && n < 300) begin
      if (raiseStart && n == 50) begin
        host_model_i.setPins(1'b0, 1'b1, 1'b0);
      end
      cyc(1);
      n++;
    end
  endtask : waitConv

  task automatic readCheck(input logic fsMode, input logic [15:0] exp, input string msg);
    host_model_i.readFrame(fsMode, word, oeN);
    check(word, exp, msg);
    check(16'(oeN), 16'h0000, "data not driven in frame");
    check(16'(devicePins.serialDataOe_n), 16'h0001, "data driven after frame");
  endtask : readCheck

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic testQualify();
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b1, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b1, 1'b0, 1'b0);
    cyc(20);
    check(16'(devicePins.busy), 16'h0000, "start honoured while deselected");
    host_model_i.setPins(1'b1, 1'b1, 1'b0);
    cyc(8);
  endtask : testQualify

  task automatic testAbort();
    sampleCode = 16'h1234;
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    check(16'(devicePins.busy), 16'h0001, "conversion not started");
    cyc(20);
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    check(16'(devicePins.busy), 16'h0000, "abort left busy high");
    check(16'(devicePins.napActive), 16'h0000, "abort did not go to wait");
    check(16'(resultValid), 16'h0001, "abort word not queued");
    check(resultWord, AbortWord, "queued abort word");
    readCheck(1'b0, AbortWord, "abort word");
  endtask : testAbort

  // Two conversions back to back, then nap because start is low at the end.
  task automatic testBackToBack();
    int n;
    sampleCode = 16'h7FFF;
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    waitConv(1'b1, n);
    check(16'(n <= ConvCycles && n >= ConvCycles - 4), 16'h0001, "conversion time");
    cyc(4);
    check(16'(devicePins.napActive), 16'h0000, "no direct sampling");
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    check(16'(devicePins.busy), 16'h0001, "back-to-back start lost");
    waitConv(1'b0, n);
    cyc(4);
    check(16'(devicePins.napActive), 16'h0001, "nap not entered");
    readCheck(1'b0, 16'h7FFF, "first full scale word");
    readCheck(1'b0, 16'h7FFF, "second full scale word");
    check(16'(nTake), 16'h0003, "results not all queued");
  endtask : testBackToBack

  task automatic testNapFrameSync();
    int n;
    sampleCode = 16'h8000;
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    check(16'(devicePins.napActive), 16'h0000, "nap kept while sampling");
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    waitConv(1'b0, n);
    cyc(4);
    check(16'(devicePins.napActive), 16'h0001, "nap not entered");
    readCheck(1'b1, 16'h8000, "frame sync word");
  endtask : testNapFrameSync

  // Frame sync stays high across busy falling, so the fresh MSB must replace the old one.
  task automatic testReload();
    int n;
    sampleCode = 16'h0001;
    host_model_i.hostPins.frameSyncIn = 1'b0;
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.hostPins.frameSyncIn = 1'b1;
    cyc(8);
    check(16'(devicePins.serialDataOut), 16'h0001, "old MSB at frame sync rise");
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    waitConv(1'b0, n);
    cyc(2);
    check(16'(devicePins.serialDataOut), 16'h0000, "no reload at busy fall");
  endtask : testReload

  task automatic testPowerDown();
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(30);
    host_model_i.setPins(1'b0, 1'b0, 1'b1);
    cyc(6);
    check(16'(devicePins.busy), 16'h0000, "power down kept converting");
    check(16'(devicePins.serialDataOe_n), 16'h0001, "power down drove data");
    host_model_i.setPins(1'b0, 1'b1, 1'b0);
    cyc(8);
    host_model_i.setPins(1'b0, 1'b0, 1'b0);
    cyc(6);
    check(16'(devicePins.busy), 16'h0001, "no conversion after power down");
    host_model_i.setPins(1'b1, 1'b0, 1'b0);
    cyc(8);
  endtask : testPowerDown

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    nMismatch = 0;
    nChecks = 0;
    nTake = 0;
    rst_n = 1'b0;
    sampleCode = 16'h0000;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    cyc(4);
    testQualify();
    testAbort();
    testBackToBack();
    testNapFrameSync();
    testReload();
    testPowerDown();
    endOfTest();
  end

  // The whole run needs about 1300 cycles; this allows over twenty times that.
  initial begin
    #300us;
    nMismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    endOfTest();
  end
endmodule : test_sar_conv_readout
